/* rle_pkg.sv */
// package: constants and types of the extended log read command block
package rle_pkg;
  // command code and log addresses
  localparam logic [7:0] OPC_READ_LOG_EXT = 8'h2F;
  localparam logic [7:0] LOG_DIR = 8'h00;
  localparam logic [7:0] LOG_ERR = 8'h03;
  localparam logic [7:0] LOG_SELFTEST = 8'h07;
  localparam logic [7:0] LOG_NCQERR = 8'h10;
  localparam logic [7:0] LOG_LINKEV = 8'h11;
  localparam logic [7:0] LOG_VEND_LO = 8'h80;
  localparam logic [7:0] LOG_VEND_HI = 8'h9F;
  // log lengths in sectors and version words
  localparam logic [15:0] VEND_LOG_LEN = 16'h0010;
  localparam logic [15:0] STD_LOG_LEN = 16'h0001;
  localparam logic [15:0] DIR_VERSION = 16'h0001;
  localparam logic [7:0] ERRLOG_VERSION = 8'h01;
  localparam logic [7:0] SELFTEST_REV = 8'h01;
  // byte offsets inside a 512-byte sector
  localparam logic [8:0] LAST_OFS = 9'h1FF;
  localparam logic [8:0] ERR_INDEX_OFS = 9'h002;
  localparam logic [8:0] ERR_REC0_OFS = 9'h004;
  localparam logic [8:0] ERR_REC1_OFS = 9'h080;
  localparam logic [8:0] ERR_REC2_OFS = 9'h0FC;
  localparam logic [8:0] ERR_REC3_OFS = 9'h178;
  localparam logic [8:0] ERR_COUNT_OFS = 9'h1F4;
  localparam logic [6:0] ERR_REC_LEN = 7'h7C;
  localparam logic [8:0] ERR_MEM_DEPTH = 9'h1F0;
  localparam logic [8:0] LINKEV_CNT_OFS = 9'h004;
  // register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_SECCNT = 8'h04;
  localparam logic [7:0] ADDR_LBALO = 8'h08;
  localparam logic [7:0] ADDR_LBAMID = 8'h0C;
  localparam logic [7:0] ADDR_FEAT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_DATA = 8'h18;
  localparam logic [7:0] ADDR_ERRBYTE = 8'h1C;
  localparam logic [7:0] ADDR_ERRCOMMIT = 8'h20;
  localparam logic [7:0] ADDR_CONFIG = 8'h24;
  // status, error and config bit positions
  localparam int ST_BSY_BIT = 7;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_DRQ_BIT = 3;
  localparam int ST_ERR_BIT = 0;
  localparam int ER_ABT_BIT = 2;
  localparam int CFG_ERRLOG = 0;
  localparam int CFG_SELFTEST = 1;
  localparam int CFG_NCQ = 2;
  localparam int CFG_LINKEV = 3;
  localparam int CFG_SMART = 4;
  localparam logic [4:0] CFG_RESET = 5'h1F;
  localparam int FEAT_CLR_BIT = 0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_CAPT = 2'b10,
    ST_HOLD = 2'b11
  } rle_state_type;
endpackage : rle_pkg

/* rle_mem.sv */
// memory: byte store for the four error records, registered read
`timescale 1ns/1ps
`default_nettype none
module rle_mem #(
  parameter int DEPTH = 496,
  parameter int AW = 9
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
    rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : 8'h00;
  end
endmodule : rle_mem
`default_nettype wire

/* rle_top.sv */
// top: extended log read command engine with apb registers
// Notes on behaviour
// - command code 2Fh written to the command register starts a log read
// - log data goes out as data-in blocks, interrupt raised for each block
// - log 11h with clear flag: send counters, then zero them
// - sector count is 16 bits: current write low byte, previous write high
// - returned data starts at the requested sector whatever the count
// - log chosen by the last byte written to the lba low register
// - start sector 16 bits: current lba mid low byte, previous high byte
// - logs 00h 03h 07h 10h 11h are read-only to the host
// - logs 80h to 9Fh are host vendor logs, readable only, reading as zeros
// - extended self-test log carries its revision byte 01h and the checksum at 1FFh, no entries
// - abort on unsupported or disabled log or bad count or start
// - directory: version word at 0, count of log N at offset 2N
// - directory version reads 0001h; 0000h would mean no directory
// - each vendor log reports 16 sectors in the directory
// - faulty commands are never entered in the error log
// - error sector: version, reserved, index at 02h, records at 04h 80h FCh 178h
// - error sector ends with error count at 1F4h and checksum at 1FFh
// - error index names the latest record, 0 when empty, range 0 to 4
// - four records form a ring; unused records read as zeros
// - device error count saturates at its maximum
// - error log version byte reads 01h
`timescale 1ns/1ps
`default_nettype none
module rle_top
  import rle_pkg::*;
#(
  parameter int N_LINK_CNT = 4
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  output logic INTRQ,
  input wire logic [N_LINK_CNT-1:0] LINK_EVT
);
  rle_state_type state, next_state;
  logic [8:0] ptr, next_ptr;
  logic [7:0] log_sel, next_log_sel;
  logic [15:0] cur_sector, next_cur_sector;
  logic [15:0] rem, next_rem;
  logic [15:0] word, next_word;
  logic [7:0] sum, next_sum;
  logic clr_req, next_clr_req;
  logic abort, next_abort;
  logic intrq_set, clr_now;
  logic [7:0] cnt_cur, next_cnt_cur, cnt_prev, next_cnt_prev;
  logic [7:0] lbalo, next_lbalo;
  logic [7:0] mid_cur, next_mid_cur, mid_prev, next_mid_prev;
  logic [7:0] feat, next_feat;
  logic [4:0] cfg, next_cfg;
  logic [2:0] err_idx, next_err_idx;
  logic [3:0] err_valid, next_err_valid;
  logic [15:0] err_count, next_err_count;
  logic [15:0] link_cnt [N_LINK_CNT];
  logic [15:0] next_link_cnt [N_LINK_CNT];
  logic next_pready, next_pslverr, next_intrq;
  logic [31:0] next_prdata;
  logic acc, wr, rd_prep;
  logic [7:0] mem_rdata, byte_val, status, err_reg;
  logic [8:0] mem_waddr;
  logic mem_we;
  logic [1:0] slot_next, rd_slot;
  logic [15:0] req_cnt, req_start, len;
  logic [16:0] req_end;
  logic start_ok;

  // sector count of each supported log, zero when absent or disabled
  function automatic logic [15:0] log_len(input logic [7:0] a, input logic [4:0] c);
    logic [15:0] n;
    n = 16'h0000;
    if (a == LOG_DIR) n = STD_LOG_LEN;
    if (a == LOG_ERR && c[CFG_ERRLOG]) n = STD_LOG_LEN;
    if (a == LOG_SELFTEST && c[CFG_SELFTEST]) n = STD_LOG_LEN;
    if (a == LOG_NCQERR && c[CFG_NCQ]) n = STD_LOG_LEN;
    if (a == LOG_LINKEV && c[CFG_LINKEV]) n = STD_LOG_LEN;
    if (a >= LOG_VEND_LO && a <= LOG_VEND_HI && c[CFG_SMART]) n = VEND_LOG_LEN;
    return n;
  endfunction : log_len

  assign acc = PSEL && PENABLE && PREADY;
  assign wr = acc && PWRITE;
  assign rd_prep = PSEL && PENABLE && !PREADY && !PWRITE;
  assign req_cnt = {cnt_prev, cnt_cur};
  assign req_start = {mid_prev, mid_cur};
  assign len = log_len(lbalo, cfg);
  assign req_end = {1'b0, req_start} + {1'b0, req_cnt};
  assign start_ok = (len != 16'h0000) && (req_cnt != 16'h0000) && (req_end <= {1'b0, len});
  assign slot_next = err_idx[1:0];
  assign mem_we = wr && (PADDR == ADDR_ERRBYTE) && (PWDATA[6:0] < ERR_REC_LEN);
  assign mem_waddr = 9'({slot_next, 7'h00}) - 9'({slot_next, 2'b00}) + 9'(PWDATA[6:0]);
  assign rd_slot = (ptr < ERR_REC1_OFS) ? 2'd0 : (ptr < ERR_REC2_OFS) ? 2'd1 :
                   (ptr < ERR_REC3_OFS) ? 2'd2 : 2'd3;

  rle_mem #(
    .DEPTH(int'(ERR_MEM_DEPTH)),
    .AW(9)
  ) u_errmem (
    .clk(CLK),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(PWDATA[23:16]),
    .raddr(ptr - ERR_REC0_OFS),
    .rdata(mem_rdata)
  );

  // byte of the selected log at the current offset
  always_comb begin
    logic [15:0] dl;
    dl = log_len(ptr[8:1], cfg);
    byte_val = 8'h00;
    if (log_sel == LOG_DIR) begin
      if (ptr[8:1] == 8'h00) begin
        byte_val = ptr[0] ? DIR_VERSION[15:8] : DIR_VERSION[7:0];
      end else begin
        byte_val = ptr[0] ? dl[15:8] : dl[7:0];
      end
    end else if (log_sel == LOG_ERR) begin
      if (ptr == 9'h000) begin
        byte_val = ERRLOG_VERSION;
      end else if (ptr == ERR_INDEX_OFS) begin
        byte_val = {5'h00, err_idx};
      end else if (ptr >= ERR_REC0_OFS && ptr < ERR_COUNT_OFS) begin
        byte_val = err_valid[rd_slot] ? mem_rdata : 8'h00;
      end else if (ptr == ERR_COUNT_OFS) begin
        byte_val = err_count[7:0];
      end else if (ptr == ERR_COUNT_OFS + 9'h001) begin
        byte_val = err_count[15:8];
      end
    end else if (log_sel == LOG_SELFTEST) begin
      if (ptr == 9'h000) begin
        byte_val = SELFTEST_REV;
      end
    end else if (log_sel == LOG_LINKEV) begin
      for (int i = 0; i < N_LINK_CNT; i++) begin
        if (ptr == LINKEV_CNT_OFS + 9'(2 * i)) byte_val = link_cnt[i][7:0];
        if (ptr == LINKEV_CNT_OFS + 9'(2 * i + 1)) byte_val = link_cnt[i][15:8];
      end
    end
    if (ptr == LAST_OFS && log_sel != LOG_DIR) begin
      byte_val = 8'h00 - sum;
    end
  end

  // transfer engine
  always_comb begin
    next_state = state;
    next_ptr = ptr;
    next_log_sel = log_sel;
    next_cur_sector = cur_sector;
    next_rem = rem;
    next_word = word;
    next_sum = sum;
    next_clr_req = clr_req;
    next_abort = abort;
    intrq_set = 1'b0;
    clr_now = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (wr && PADDR == ADDR_CMD) begin
          if (PWDATA[7:0] == OPC_READ_LOG_EXT && start_ok) begin
            next_state = ST_FETCH;
            next_log_sel = lbalo;
            next_cur_sector = req_start;
            next_rem = req_cnt;
            next_ptr = 9'h000;
            next_sum = 8'h00;
            next_abort = 1'b0;
            next_clr_req = feat[FEAT_CLR_BIT] && (lbalo == LOG_LINKEV);
          end else begin
            next_abort = 1'b1;
            intrq_set = 1'b1;
          end
        end
      end
      ST_FETCH: begin
        next_state = ST_CAPT;
      end
      ST_CAPT: begin
        next_sum = sum + byte_val;
        if (!ptr[0]) begin
          next_word[7:0] = byte_val;
          next_ptr = ptr + 9'h001;
          next_state = ST_FETCH;
        end else begin
          next_word[15:8] = byte_val;
          next_state = ST_HOLD;
          intrq_set = (ptr == 9'h001);
        end
      end
      ST_HOLD: begin
        if (acc && !PWRITE && PADDR == ADDR_DATA) begin
          next_state = ST_FETCH;
          if (ptr == LAST_OFS) begin
            next_ptr = 9'h000;
            next_sum = 8'h00;
            next_rem = rem - 16'h0001;
            next_cur_sector = cur_sector + 16'h0001;
            if (rem == 16'h0001) begin
              next_state = ST_IDLE;
              clr_now = clr_req;
              next_clr_req = 1'b0;
            end
          end else begin
            next_ptr = ptr + 9'h001;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state <= ST_IDLE;
      ptr <= 9'h000;
      log_sel <= 8'h00;
      cur_sector <= 16'h0000;
      rem <= 16'h0000;
      word <= 16'h0000;
      sum <= 8'h00;
      clr_req <= 1'b0;
      abort <= 1'b0;
    end else begin
      state <= next_state;
      ptr <= next_ptr;
      log_sel <= next_log_sel;
      cur_sector <= next_cur_sector;
      rem <= next_rem;
      word <= next_word;
      sum <= next_sum;
      clr_req <= next_clr_req;
      abort <= next_abort;
    end
  end

  // command parameters, error log bookkeeping and link counters
  always_comb begin
    next_cnt_cur = cnt_cur;
    next_cnt_prev = cnt_prev;
    next_lbalo = lbalo;
    next_mid_cur = mid_cur;
    next_mid_prev = mid_prev;
    next_feat = feat;
    next_cfg = cfg;
    next_err_idx = err_idx;
    next_err_valid = err_valid;
    next_err_count = err_count;
    if (wr && PADDR == ADDR_SECCNT) begin
      next_cnt_prev = cnt_cur;
      next_cnt_cur = PWDATA[7:0];
    end
    if (wr && PADDR == ADDR_LBALO) next_lbalo = PWDATA[7:0];
    if (wr && PADDR == ADDR_LBAMID) begin
      next_mid_prev = mid_cur;
      next_mid_cur = PWDATA[7:0];
    end
    if (wr && PADDR == ADDR_FEAT) next_feat = PWDATA[7:0];
    if (wr && PADDR == ADDR_CONFIG) next_cfg = PWDATA[4:0];
    if (mem_we) next_err_valid[slot_next] = 1'b0;
    if (wr && PADDR == ADDR_ERRCOMMIT && PWDATA[0] && !PWDATA[1]) begin
      next_err_valid[slot_next] = 1'b1;
      next_err_idx = {1'b0, slot_next} + 3'd1;
      if (err_count != 16'hFFFF) next_err_count = err_count + 16'h0001;
    end
    for (int i = 0; i < N_LINK_CNT; i++) begin
      next_link_cnt[i] = link_cnt[i];
      if (clr_now) begin
        next_link_cnt[i] = {15'h0000, LINK_EVT[i]};
      end else if (LINK_EVT[i] && link_cnt[i] != 16'hFFFF) begin
        next_link_cnt[i] = link_cnt[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      cnt_cur <= 8'h00;
      cnt_prev <= 8'h00;
      lbalo <= 8'h00;
      mid_cur <= 8'h00;
      mid_prev <= 8'h00;
      feat <= 8'h00;
      cfg <= CFG_RESET;
      err_idx <= 3'd0;
      err_valid <= 4'h0;
      err_count <= 16'h0000;
      for (int i = 0; i < N_LINK_CNT; i++) link_cnt[i] <= 16'h0000;
    end else begin
      cnt_cur <= next_cnt_cur;
      cnt_prev <= next_cnt_prev;
      lbalo <= next_lbalo;
      mid_cur <= next_mid_cur;
      mid_prev <= next_mid_prev;
      feat <= next_feat;
      cfg <= next_cfg;
      err_idx <= next_err_idx;
      err_valid <= next_err_valid;
      err_count <= next_err_count;
      for (int i = 0; i < N_LINK_CNT; i++) link_cnt[i] <= next_link_cnt[i];
    end
  end

  // apb slave: one wait state, data reads stall while a word is built
  always_comb begin
    status = 8'h00;
    status[ST_BSY_BIT] = (state == ST_FETCH) || (state == ST_CAPT);
    status[ST_RDY_BIT] = 1'b1;
    status[ST_DRQ_BIT] = (state == ST_HOLD);
    status[ST_ERR_BIT] = abort;
    err_reg = 8'h00;
    err_reg[ER_ABT_BIT] = abort;
    next_pready = PSEL && PENABLE && !PREADY &&
                  !(!PWRITE && PADDR == ADDR_DATA && status[ST_BSY_BIT]);
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    unique case (PADDR)
      ADDR_CMD: next_prdata = {24'h00_0000, status};
      ADDR_SECCNT: next_prdata = {16'h0000, cnt_prev, cnt_cur};
      ADDR_LBALO: next_prdata = {24'h00_0000, lbalo};
      ADDR_LBAMID: next_prdata = {16'h0000, mid_prev, mid_cur};
      ADDR_FEAT: next_prdata = {24'h00_0000, feat};
      ADDR_STATUS: next_prdata = {cur_sector, err_reg, status};
      ADDR_DATA: next_prdata = (state == ST_HOLD) ? {16'h0000, word} : 32'h0000_0000;
      ADDR_ERRBYTE: next_prdata = 32'h0000_0000;
      ADDR_ERRCOMMIT: next_prdata = {13'h0000, err_idx, err_count};
      ADDR_CONFIG: next_prdata = {27'h000_0000, cfg};
      default: next_pslverr = next_pready;
    endcase
    if (!rd_prep) next_prdata = 32'h0000_0000;
    next_intrq = (INTRQ && !(acc && !PWRITE && PADDR == ADDR_STATUS)) || intrq_set;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      INTRQ <= 1'b0;
    end else begin
      PREADY <= next_pready;
      PRDATA <= next_prdata;
      PSLVERR <= next_pslverr;
      INTRQ <= next_intrq;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_cmd_start: assert property (
    (state == ST_IDLE && wr && PADDR == ADDR_CMD && PWDATA[7:0] == OPC_READ_LOG_EXT && start_ok)
    |=> (state == ST_FETCH && !abort && log_sel == $past(lbalo)))
    else $error("valid log read did not start");
  a_bad_abort: assert property (
    (state == ST_IDLE && wr && PADDR == ADDR_CMD && !start_ok) |=> (abort && state == ST_IDLE ##1 INTRQ))
    else $error("invalid log read not aborted");
  a_block_intr: assert property (
    (state == ST_CAPT && ptr == 9'h001) |=> INTRQ)
    else $error("no interrupt for data block");
  a_count_build: assert property (
    (wr && PADDR == ADDR_SECCNT) |=> (req_cnt == {$past(cnt_cur), $past(PWDATA[7:0])}))
    else $error("sector count bytes misplaced");
  a_first_sector: assert property (
    (state == ST_IDLE && next_state == ST_FETCH) |=> (cur_sector == $past(req_start)))
    else $error("transfer began at wrong sector");
  a_cnt_clear: assert property (
    clr_now |=> (link_cnt[0] <= 16'h0001) ##1 (link_cnt[0] <= 16'h0002))
    else $error("link counters not cleared");
  a_vend_len: assert property (
    (state == ST_CAPT && log_sel == LOG_DIR && ptr[8:1] >= LOG_VEND_LO && ptr[8:1] <= LOG_VEND_HI
     && !ptr[0] && cfg[CFG_SMART]) |-> (byte_val == VEND_LOG_LEN[7:0]))
    else $error("vendor log length wrong");
  a_sum_zero: assert property (
    (state == ST_CAPT && ptr == LAST_OFS && log_sel != LOG_DIR) |=> (sum == 8'h00)[*2])
    else $error("sector checksum not zero");
  a_errcnt_sat: assert property (
    1'b1 |=> (err_count >= $past(err_count)))
    else $error("error count wrapped");
  a_index_range: assert property (
    err_idx <= 3'd4)
    else $error("error index out of range");
  a_index_write: assert property (
    $changed(err_idx) |-> ($past(wr) && $past(PADDR) == ADDR_ERRCOMMIT))
    else $error("error index moved without commit");
endmodule : rle_top
`default_nettype wire

/* rle_host.sv */
// host model: apb master that issues register cycles to the log engine
`timescale 1ns/1ps
`default_nettype none
module rle_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : rle_host
`default_nettype wire

/* tb_top.sv */
// testbench: log read engine driven over apb by the host model
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module tb_top
  import rle_pkg::*;
;
  localparam int NL = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [NL-1:0] link_evt = '0;
  logic psel, penable, pwrite, pready, pslverr, intrq, serr;
  logic [7:0] paddr, vend;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] seed = 16'h0049;
  logic [7:0] exp_sec [512];
  logic [15:0] link_cnt [NL];
  logic [6:0] err_ofs;
  logic [7:0] err_val;
  int err_count = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  rle_top #(.N_LINK_CNT(NL)) u_dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .INTRQ(intrq), .LINK_EVT(link_evt));
  rle_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [15:0] log_len(input logic [7:0] n);
    if (n == 8'h03 || n == 8'h07 || n == 8'h10 || n == 8'h11) return 16'h0001;
    if (n >= 8'h80 && n <= 8'h9F) return 16'h0010;
    return 16'h0000;
  endfunction : log_len
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd, serr);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0000_0000, rd, serr);
  endtask : rdr
  // expected sector image of one log
  task automatic fill_exp(input logic [7:0] lg);
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < 512; i++) exp_sec[i] = 8'h00;
    case (lg)
      8'h00: begin
        exp_sec[0] = 8'h01;
        for (int n = 1; n < 256; n++) {exp_sec[2*n+1], exp_sec[2*n]} = log_len(8'(n));
      end
      8'h03: begin
        exp_sec[0] = 8'h01;
        exp_sec[2] = 8'h01;
        exp_sec[4+err_ofs] = err_val;
        exp_sec[9'h1F4] = 8'h01;
      end
      8'h07: exp_sec[0] = 8'h01;
      8'h11: for (int i = 0; i < NL; i++) {exp_sec[5+2*i], exp_sec[4+2*i]} = link_cnt[i];
      default: ;
    endcase
    if (lg != 8'h00) begin
      for (int i = 0; i < 511; i++) sum += exp_sec[i];
      exp_sec[511] = 8'h00 - sum;
    end
  endtask : fill_exp
  task automatic run_log(input logic [7:0] lg, input logic [15:0] st, input logic [15:0] cnt,
                         input logic clr, input logic ab);
    int n;
    int ns;
    ns = ab ? 1 : int'(cnt);
    wr(ADDR_SECCNT, {24'h0, cnt[15:8]});
    wr(ADDR_SECCNT, {24'h0, cnt[7:0]});
    wr(ADDR_LBAMID, {24'h0, st[15:8]});
    wr(ADDR_LBAMID, {24'h0, st[7:0]});
    wr(ADDR_LBALO, {24'h0, lg});
    wr(ADDR_FEAT, {31'h0, clr});
    fill_exp(lg);
    wr(ADDR_CMD, 32'h0000_002F);
    for (int s = 0; s < ns; s++) begin
      n = 0;
      while (intrq !== 1'b1 && n < 100) begin
        n++;
        @(posedge clk);
      end
      `CHK(intrq, 1'b1)
      rdr(ADDR_STATUS);
      `CHK(rd[ST_ERR_BIT], ab)
      `CHK(rd[8+ER_ABT_BIT], ab)
      `CHK(rd[ST_DRQ_BIT], ~ab)
      @(posedge clk);
      `CHK(intrq, 1'b0)
      if (!ab) begin
        `CHK(rd[31:16], st + 16'(s))
        for (int k = 0; k < 256; k++) begin
          rdr(ADDR_DATA);
          `CHK(rd[15:0], {exp_sec[2*k+1], exp_sec[2*k]})
        end
      end
    end
  endtask : run_log
  task automatic print_verdict();
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #(25 * 60000);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdr(ADDR_CONFIG);
    `CHK(rd, 32'h0000_001F)
    rdr(8'h40);
    `CHK(serr, 1'b1)
    rdr(ADDR_ERRCOMMIT);
    `CHK(rd, 32'h0000_0000)
    wr(ADDR_SECCNT, 32'h0000_0001);
    wr(ADDR_CMD, 32'h0000_0060);
    repeat (2) @(posedge clk);
    `CHK(intrq, 1'b1)
    rdr(ADDR_STATUS);
    `CHK(rd[ST_ERR_BIT], 1'b1)
    `CHK(rd[ST_DRQ_BIT], 1'b0)
    run_log(8'h00, 16'h0000, 16'h0001, 1'b0, 1'b0);
    seed = lfsr(seed);
    err_ofs = seed[6:0] % 7'd124;
    err_val = seed[15:8] | 8'h01;
    wr(ADDR_ERRBYTE, {8'h0, err_val, 9'h0, err_ofs});
    wr(ADDR_ERRCOMMIT, 32'h0000_0001);
    wr(ADDR_ERRCOMMIT, 32'h0000_0003);
    rdr(ADDR_ERRCOMMIT);
    `CHK(rd[18:0], 19'h1_0001)
    run_log(8'h03, 16'h0000, 16'h0001, 1'b0, 1'b0);
    run_log(8'h07, 16'h0000, 16'h0001, 1'b0, 1'b0);
    run_log(8'h10, 16'h0000, 16'h0001, 1'b0, 1'b0);
    for (int i = 0; i < NL; i++) link_cnt[i] = 16'h0000;
    repeat (60) begin
      seed = lfsr(seed);
      link_evt <= seed[NL-1:0];
      for (int i = 0; i < NL; i++) link_cnt[i] += 16'(seed[i]);
      @(posedge clk);
    end
    link_evt <= '0;
    run_log(8'h11, 16'h0000, 16'h0001, 1'b0, 1'b0);
    run_log(8'h11, 16'h0000, 16'h0001, 1'b1, 1'b0);
    for (int i = 0; i < NL; i++) link_cnt[i] = 16'h0000;
    run_log(8'h11, 16'h0000, 16'h0001, 1'b0, 1'b0);
    seed = lfsr(seed);
    vend = 8'h80 | {3'b000, seed[4:0]};
    run_log(vend, 16'h000E, 16'h0002, 1'b0, 1'b0);
    run_log(vend, 16'h000F, 16'h0002, 1'b0, 1'b1);
    run_log(8'h05, 16'h0000, 16'h0001, 1'b0, 1'b1);
    run_log(8'h00, 16'h0000, 16'h0000, 1'b0, 1'b1);
    run_log(8'h03, 16'h0001, 16'h0001, 1'b0, 1'b1);
    wr(ADDR_CONFIG, 32'h0000_001E);
    run_log(8'h03, 16'h0000, 16'h0001, 1'b0, 1'b1);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
